// *** hw/ihc_host.sv ***
// I2C host sequencer: drives the controller's registers on behalf of software.
`timescale 1ns/1ns
module ihc_host #(
   parameter int FREE_CYCLES = ihc_pkg::FRAME_CYCLES,
   parameter int FALL_CYC = ihc_pkg::FALL_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   output logic dev_cs_o,
   output logic dev_we_o,
   output logic [2:0] dev_addr_o,
   output logic [7:0] dev_wdata_o,
   input wire logic [7:0] dev_rdata_i,
   input wire logic dev_ack_i,
   input wire logic transfer_interrupt_i,
   input wire logic serial_clock_pin_i,
   input wire logic serial_data_pin_i
);
   ihc_pkg::ihc_state_type state_r, state_nxt;
   ihc_pkg::ihc_op_type mop;
   logic [3:0] step_r, step_nxt, mjmp;
   logic [2:0] cmd_r, mreg, dev_addr_nxt;
   logic [7:0] mval, dev_wdata_nxt, st_r, st_nxt, rx_r, rx_nxt, rd_r, rd_nxt, tx_r, en_cnt_r;
   logic [17:0] cfg_r;
   logic [3:0] irq_st_r, irq_st_nxt, mask_r, ev;
   logic [15:0] dly_r, dly_nxt, dly_sum, dly_len;
   logic dev_cs_nxt, dev_we_nxt, start_status_flag_r, start_status_flag_nxt, seen_r, seen_nxt, int_seen_r, consume;
   logic ev_done, ev_nack, ev_arb, ev_late;
   logic [2:0] level;
   logic start_det, int_edge, bus_free;
   ihc_line_sync #(.FREE_CYCLES(FREE_CYCLES)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .lines_i({transfer_interrupt_i, serial_data_pin_i, serial_clock_pin_i}),
      .level_o(level),
      .start_o(start_det),
      .int_edge_o(int_edge),
      .bus_free_o(bus_free)
   );
   // ==========================================================
   // Wishbone decode
   wire hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = hit & wb_we_i;
   wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire sel_cmd = wb_adr_i[7:2] == ihc_pkg::HR_CMD[7:2];
   wire sel_cfg = wb_adr_i[7:2] == ihc_pkg::HR_CFG[7:2];
   wire sel_data = wb_adr_i[7:2] == ihc_pkg::HR_DATA[7:2];
   wire sel_stat = wb_adr_i[7:2] == ihc_pkg::HR_STAT[7:2];
   wire sel_irq = wb_adr_i[7:2] == ihc_pkg::HR_IRQ[7:2];
   wire sel_mask = wb_adr_i[7:2] == ihc_pkg::HR_MASK[7:2];
   wire busy = state_r != ihc_pkg::S_IDLE;
   wire cmd_go = wr & sel_cmd & wb_sel_i[0] & ~busy & (wb_dat_i[2:0] != 3'h0);
   wire [17:0] cfg_w = (cfg_r & ~lane[17:0]) | (wb_dat_i[17:0] & lane[17:0]);
   wire [3:0] irq_clr = (wr & sel_irq & wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
   wire [31:0] stat_word = {25'h0, level[1], level[0], st_r[ihc_pkg::ST_TRC], start_status_flag_r,
      st_r[ihc_pkg::ST_MASTER_STATE_FLAG], st_r[ihc_pkg::ST_ACK_DETECTED], busy};
   wire [31:0] rdat = sel_cmd ? {29'h0, cmd_r} :
      sel_cfg ? {14'h0, cfg_r} :
      sel_data ? {24'h0, rx_r} :
      sel_stat ? stat_word :
      sel_irq ? {28'h0, irq_st_r} :
      sel_mask ? {28'h0, mask_r} : 32'h0;
   wire start_without_stop_enable = cfg_r[ihc_pkg::CFG_START_WITHOUT_STOP_ENABLE];
   wire multi = cfg_r[ihc_pkg::CFG_MULTI];
   wire trig_busy = (rd_r & ihc_pkg::CTL_TRIG) != 8'h00;
   wire [7:0] on_base = ihc_pkg::CTL_BASE | ihc_pkg::CTL_IE;
   wire [7:0] join_base = ihc_pkg::CTL_BASE & ~ihc_pkg::CTL_STOP_INTERRUPT_ENABLE;
   wire [7:0] last_rx = (on_base & ~ihc_pkg::CTL_ACK_ENABLE) | ihc_pkg::CTL_WAIT_TIMING_SELECT | ihc_pkg::CTL_WAIT_RELEASE;
   wire rejected = cmd_r == ihc_pkg::CMD_START && step_r == 4'h8 && rd_r[ihc_pkg::FLAG_START_STATUS_FLAG];
   // The wait covers both width settings, four clocks and two line fall times.
   assign dly_sum = {8'h00, cfg_r[7:0]} + {8'h00, cfg_r[15:8]} + ihc_pkg::START_FIXED_CYC
      + 16'(2 * FALL_CYC);
   assign dly_len = (dly_sum < ihc_pkg::REJECT_CYC) ? ihc_pkg::REJECT_CYC : dly_sum;
   assign ev = {ev_late, ev_arb, ev_nack, ev_done};
   assign irq_st_nxt = (irq_st_r & ~irq_clr) | ev;
   // ==========================================================
   // Command microprograms: one step per device access, wait or branch.
   always_comb
   begin
      mop = ihc_pkg::OP_END;
      mreg = ihc_pkg::DEV_CTL0;
      mval = 8'h00;
      mjmp = step_r + 4'h1;
      case (cmd_r)
         ihc_pkg::CMD_INIT:
            case (step_r)
               4'h0: begin mop = ihc_pkg::OP_WR; mreg = ihc_pkg::DEV_LOW; mval = cfg_r[7:0]; end
               4'h1: begin mop = ihc_pkg::OP_WR; mreg = ihc_pkg::DEV_HIGH; mval = cfg_r[15:8]; end
               4'h2: begin mop = ihc_pkg::OP_WR; mreg = ihc_pkg::DEV_FLAG; mval = {6'h00, start_without_stop_enable, 1'b0}; end
               4'h3: begin mop = ihc_pkg::OP_WR; mval = ihc_pkg::CTL_BASE; end
               4'h4: begin mop = ihc_pkg::OP_WR; mval = on_base; end
               4'h5: if (!start_without_stop_enable) begin mop = ihc_pkg::OP_WR; mval = on_base | ihc_pkg::CTL_SPT; end
               4'h6: if (!start_without_stop_enable) mop = ihc_pkg::OP_INT;
               default: mop = ihc_pkg::OP_END;
            endcase
         ihc_pkg::CMD_JOIN:
            case (step_r)
               4'h0: begin mop = ihc_pkg::OP_WR; mval = join_base; end
               4'h1: begin mop = ihc_pkg::OP_WR; mval = join_base | ihc_pkg::CTL_IE; end
               4'h2: mop = ihc_pkg::OP_SDET;
               4'h3: begin mop = ihc_pkg::OP_WR; mval = join_base | ihc_pkg::CTL_IE | ihc_pkg::CTL_LEAVE_BUS_RELEASE; end
               default: mop = ihc_pkg::OP_END;
            endcase
         ihc_pkg::CMD_START:
            case (step_r)
               4'h0: mop = ihc_pkg::OP_FREE;
               4'h1: mop = ihc_pkg::OP_RD;
               4'h2: begin mop = ihc_pkg::OP_NOP; mjmp = trig_busy ? 4'h1 : 4'h3; end
               4'h3: begin mop = ihc_pkg::OP_WR; mval = on_base | ihc_pkg::CTL_STT; end
               4'h4: mop = ihc_pkg::OP_DLY;
               4'h5: begin mop = ihc_pkg::OP_RD; mreg = ihc_pkg::DEV_STATUS; end
               4'h6: begin mop = ihc_pkg::OP_NOP; mjmp = st_r[ihc_pkg::ST_MASTER_STATE_FLAG] ? 4'h9 : 4'h7; end
               4'h7: begin mop = ihc_pkg::OP_RD; mreg = ihc_pkg::DEV_FLAG; end
               // A reserved start waits for the stop interrupt before loading the address.
               4'h8: if (!rd_r[ihc_pkg::FLAG_START_STATUS_FLAG]) mop = ihc_pkg::OP_INT;
               4'h9: begin mop = ihc_pkg::OP_WR; mreg = ihc_pkg::DEV_SHIFT; mval = tx_r; end
               4'hA: mop = ihc_pkg::OP_INT;
               4'hB: begin mop = ihc_pkg::OP_RD; mreg = ihc_pkg::DEV_STATUS; end
               default: mop = ihc_pkg::OP_END;
            endcase
         ihc_pkg::CMD_WRITE:
            case (step_r)
               4'h0: begin mop = ihc_pkg::OP_WR; mreg = ihc_pkg::DEV_SHIFT; mval = tx_r; end
               4'h1: mop = ihc_pkg::OP_INT;
               4'h2: begin mop = ihc_pkg::OP_RD; mreg = ihc_pkg::DEV_STATUS; end
               default: mop = ihc_pkg::OP_END;
            endcase
         ihc_pkg::CMD_READ, ihc_pkg::CMD_READ_LAST:
            case (step_r)
               4'h0:
               begin
                  mop = ihc_pkg::OP_WR;
                  mval = (cmd_r == ihc_pkg::CMD_READ) ? (on_base | ihc_pkg::CTL_WAIT_RELEASE) : last_rx;
               end
               4'h1: mop = ihc_pkg::OP_INT;
               4'h2: begin mop = ihc_pkg::OP_RD; mreg = ihc_pkg::DEV_SHIFT; end
               4'h3: if (cmd_r == ihc_pkg::CMD_READ_LAST) mop = ihc_pkg::OP_RD;
               4'h4: begin mop = ihc_pkg::OP_NOP; mjmp = trig_busy ? 4'h3 : 4'h5; end
               4'h5: begin mop = ihc_pkg::OP_WR; mval = on_base | ihc_pkg::CTL_SPT; end
               4'h6: mop = ihc_pkg::OP_INT;
               default: mop = ihc_pkg::OP_END;
            endcase
         ihc_pkg::CMD_STOP:
            case (step_r)
               4'h0: mop = ihc_pkg::OP_RD;
               4'h1: begin mop = ihc_pkg::OP_NOP; mjmp = trig_busy ? 4'h0 : 4'h2; end
               4'h2: begin mop = ihc_pkg::OP_WR; mval = on_base | ihc_pkg::CTL_SPT; end
               4'h3: mop = ihc_pkg::OP_INT;
               default: mop = ihc_pkg::OP_END;
            endcase
         default: mop = ihc_pkg::OP_END;
      endcase
   end
   // ==========================================================
   // Sequencer
   always_comb
   begin
      state_nxt = state_r;
      step_nxt = step_r;
      dev_cs_nxt = dev_cs_o;
      dev_we_nxt = dev_we_o;
      dev_addr_nxt = dev_addr_o;
      dev_wdata_nxt = dev_wdata_o;
      rd_nxt = rd_r;
      st_nxt = st_r;
      rx_nxt = rx_r;
      start_status_flag_nxt = start_status_flag_r;
      dly_nxt = dly_r;
      seen_nxt = seen_r;
      consume = 1'b0;
      ev_done = 1'b0;
      ev_nack = 1'b0;
      ev_arb = 1'b0;
      ev_late = 1'b0;
      case (state_r)
         ihc_pkg::S_IDLE:
            if (cmd_go)
            begin
               state_nxt = ihc_pkg::S_STEP;
               step_nxt = 4'h0;
               start_status_flag_nxt = 1'b0;
            end
         ihc_pkg::S_STEP:
         begin
            step_nxt = mjmp;
            case (mop)
               ihc_pkg::OP_WR:
               begin
                  dev_cs_nxt = 1'b1;
                  dev_we_nxt = 1'b1;
                  dev_addr_nxt = mreg;
                  dev_wdata_nxt = mval;
                  state_nxt = ihc_pkg::S_BUS;
               end
               ihc_pkg::OP_RD:
               begin
                  dev_cs_nxt = 1'b1;
                  dev_we_nxt = 1'b0;
                  dev_addr_nxt = mreg;
                  state_nxt = ihc_pkg::S_BUS;
               end
               ihc_pkg::OP_INT: state_nxt = ihc_pkg::S_INT;
               ihc_pkg::OP_DLY:
               begin
                  dly_nxt = dly_len;
                  state_nxt = ihc_pkg::S_DLY;
               end
               ihc_pkg::OP_FREE: state_nxt = ihc_pkg::S_FREE;
               ihc_pkg::OP_SDET:
               begin
                  seen_nxt = 1'b0;
                  state_nxt = ihc_pkg::S_SDET;
               end
               ihc_pkg::OP_NOP: state_nxt = ihc_pkg::S_STEP;
               default:
               begin
                  ev_done = 1'b1;
                  ev_arb = rejected;
                  start_status_flag_nxt = rejected;
                  state_nxt = ihc_pkg::S_IDLE;
               end
            endcase
         end
         ihc_pkg::S_BUS:
            if (dev_ack_i)
            begin
               dev_cs_nxt = 1'b0;
               state_nxt = ihc_pkg::S_STEP;
               if (!dev_we_o)
               begin
                  rd_nxt = dev_rdata_i;
                  if (dev_addr_o == ihc_pkg::DEV_SHIFT)
                     rx_nxt = dev_rdata_i;
                  if (dev_addr_o == ihc_pkg::DEV_STATUS)
                  begin
                     st_nxt = dev_rdata_i;
                     // The status read that only probes for a reservation reports nothing.
                     if (!(cmd_r == ihc_pkg::CMD_START && step_r == 4'h6))
                     begin
                        ev_nack = ~dev_rdata_i[ihc_pkg::ST_ACK_DETECTED];
                        ev_arb = ~dev_rdata_i[ihc_pkg::ST_MASTER_STATE_FLAG];
                     end
                  end
               end
            end
         ihc_pkg::S_INT:
            if (int_seen_r)
            begin
               consume = 1'b1;
               state_nxt = ihc_pkg::S_STEP;
            end
         ihc_pkg::S_DLY:
            if (dly_r <= 16'h0001)
               state_nxt = ihc_pkg::S_STEP;
            else
               dly_nxt = dly_r - 16'h0001;
         ihc_pkg::S_FREE:
            if (!multi || bus_free)
               state_nxt = ihc_pkg::S_STEP;
         ihc_pkg::S_SDET:
         begin
            if (start_det)
               seen_nxt = 1'b1;
            if (seen_r && en_cnt_r >= ihc_pkg::JOIN_MIN_CYC)
            begin
               state_nxt = ihc_pkg::S_STEP;
               ev_late = en_cnt_r > ihc_pkg::JOIN_MAX_CYC;
            end
         end
         default: state_nxt = ihc_pkg::S_IDLE;
      endcase
   end
   // ==========================================================
   // Registers
   wire join_en_done = cmd_r == ihc_pkg::CMD_JOIN && state_r == ihc_pkg::S_BUS && dev_ack_i && step_r == 4'h2;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= ihc_pkg::S_IDLE;
         step_r <= 4'h0;
         {dev_cs_o, dev_we_o, dev_addr_o, dev_wdata_o} <= 13'h0000;
         {rd_r, st_r, rx_r, tx_r, en_cnt_r} <= 40'h0000000000;
         {start_status_flag_r, seen_r, int_seen_r, wb_ack_o, irq_o} <= 5'h00;
         {cmd_r, irq_st_r, mask_r, dly_r} <= 27'h0000000;
         cfg_r <= ihc_pkg::CFG_RESET;
         wb_dat_o <= 32'h00000000;
      end
      else if (ce_i)
      begin
         state_r <= state_nxt;
         step_r <= step_nxt;
         {dev_cs_o, dev_we_o, dev_addr_o, dev_wdata_o} <= {dev_cs_nxt, dev_we_nxt, dev_addr_nxt, dev_wdata_nxt};
         {rd_r, st_r, rx_r, start_status_flag_r, seen_r, dly_r} <= {rd_nxt, st_nxt, rx_nxt, start_status_flag_nxt, seen_nxt, dly_nxt};
         // A new interrupt edge wins over consuming an earlier one.
         int_seen_r <= int_edge | (int_seen_r & ~consume & busy);
         en_cnt_r <= join_en_done ? 8'h00 : (en_cnt_r == 8'hFF ? en_cnt_r : en_cnt_r + 8'h01);
         irq_st_r <= irq_st_nxt;
         irq_o <= |(irq_st_r & mask_r);
         wb_ack_o <= hit;
         if (hit)
            wb_dat_o <= rdat;
         if (cmd_go)
            cmd_r <= wb_dat_i[2:0];
         if (wr & sel_cfg)
            cfg_r <= cfg_w;
         if (wr & sel_data & wb_sel_i[0])
            tx_r <= wb_dat_i[7:0];
         if (wr & sel_mask & wb_sel_i[0])
            mask_r <= wb_dat_i[3:0];
      end
   end
endmodule

// *** hw/ihc_line_sync.sv ***
// Pin synchronisers, start detection, interrupt edge and bus-free timer.
`timescale 1ns/1ns
module ihc_line_sync #(
   parameter int FREE_CYCLES = ihc_pkg::FRAME_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [2:0] lines_i,
   output logic [2:0] level_o,
   output logic start_o,
   output logic int_edge_o,
   output logic bus_free_o
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic [2:0] prev_r;
   logic [15:0] free_r;
   // ==========================================================
   // Two-stage synchronisers; bit 0 clock line, bit 1 data line, bit 2 interrupt.
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               meta_r[g] <= 1'b1;
               sync_r[g] <= 1'b1;
               prev_r[g] <= 1'b1;
            end
            else if (ce_i)
            begin
               meta_r[g] <= lines_i[g];
               sync_r[g] <= meta_r[g];
               prev_r[g] <= sync_r[g];
            end
         end
      end
   endgenerate
   // Interrupt line resets high so reset itself is never taken for an edge.
   assign level_o = sync_r;
   assign start_o = prev_r[1] & ~sync_r[1] & sync_r[0] & prev_r[0];
   assign int_edge_o = sync_r[2] & ~prev_r[2];
   assign bus_free_o = (free_r == 16'(FREE_CYCLES));
   // ==========================================================
   // Bus-free timer: both lines high without a break for one frame.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         free_r <= 16'h0000;
      else if (ce_i)
      begin
         if (!(sync_r[0] & sync_r[1]))
            free_r <= 16'h0000;
         else if (!bus_free_o)
            free_r <= free_r + 16'h0001;
      end
   end
endmodule

// *** hw/ihc_pkg.sv ***
// Constants and types shared by the I2C host sequencer files.
package ihc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int FALL_TIME_NS = 300;
   localparam int FALL_CYCLES = (FALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FRAME_TIME_NS = 288;
   localparam int FRAME_CYCLES = (FRAME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] START_FIXED_CYC = 16'h0004;
   localparam logic [15:0] REJECT_CYC = 16'h0005;
   localparam logic [7:0] JOIN_MIN_CYC = 8'h04;
   localparam logic [7:0] JOIN_MAX_CYC = 8'h50;
   // ==========================================================
   // Device register selectors
   localparam logic [2:0] DEV_CTL0 = 3'h0;
   localparam logic [2:0] DEV_STATUS = 3'h1;
   localparam logic [2:0] DEV_FLAG = 3'h2;
   localparam logic [2:0] DEV_SHIFT = 3'h3;
   localparam logic [2:0] DEV_LOW = 3'h4;
   localparam logic [2:0] DEV_HIGH = 3'h5;
   // ==========================================================
   // Device register fields
   localparam logic [7:0] CTL_IE = 8'h80;
   localparam logic [7:0] CTL_LEAVE_BUS_RELEASE = 8'h40;
   localparam logic [7:0] CTL_WAIT_RELEASE = 8'h20;
   localparam logic [7:0] CTL_STOP_INTERRUPT_ENABLE = 8'h10;
   localparam logic [7:0] CTL_WAIT_TIMING_SELECT = 8'h08;
   localparam logic [7:0] CTL_ACK_ENABLE = 8'h04;
   localparam logic [7:0] CTL_STT = 8'h02;
   localparam logic [7:0] CTL_SPT = 8'h01;
   localparam logic [7:0] CTL_BASE = 8'h1C;
   localparam logic [7:0] CTL_TRIG = 8'h03;
   localparam int ST_MASTER_STATE_FLAG = 7;
   localparam int ST_TRC = 3;
   localparam int ST_ACK_DETECTED = 2;
   localparam int FLAG_START_STATUS_FLAG = 7;
   localparam int FLAG_START_WITHOUT_STOP_ENABLE = 1;
   // ==========================================================
   // Host register map, byte addresses
   localparam logic [7:0] HR_CMD = 8'h00;
   localparam logic [7:0] HR_CFG = 8'h04;
   localparam logic [7:0] HR_DATA = 8'h08;
   localparam logic [7:0] HR_STAT = 8'h0C;
   localparam logic [7:0] HR_IRQ = 8'h10;
   localparam logic [7:0] HR_MASK = 8'h14;
   localparam logic [17:0] CFG_RESET = 18'h00000;
   localparam int CFG_START_WITHOUT_STOP_ENABLE = 16;
   localparam int CFG_MULTI = 17;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_NACK = 1;
   localparam int IRQ_ARB = 2;
   localparam int IRQ_LATE = 3;
   // ==========================================================
   // Commands
   localparam logic [2:0] CMD_INIT = 3'h1;
   localparam logic [2:0] CMD_JOIN = 3'h2;
   localparam logic [2:0] CMD_START = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_READ_LAST = 3'h6;
   localparam logic [2:0] CMD_STOP = 3'h7;
   typedef enum logic [2:0] {S_IDLE, S_STEP, S_BUS, S_INT, S_DLY, S_FREE, S_SDET} ihc_state_type;
   typedef enum logic [2:0] {OP_END, OP_WR, OP_RD, OP_INT, OP_DLY, OP_FREE, OP_SDET, OP_NOP} ihc_op_type;
endpackage

// *** tb/ihc_dev_model.sv ***
// Behavioural model of the controller's register port and transfer interrupt.
`timescale 1ns/1ns
module ihc_dev_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_i,
   input wire logic we_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic slow_i,
   input wire logic nack_i,
   input wire logic busy_i,
   output logic ack_o,
   output logic [7:0] rdata_o,
   output logic int_o
);
   logic [7:0] ctl_r, flag_r, val;
   logic [3:0] wait_r, icnt_r, tcnt_r;
   wire take = cs_i && !ack_o && wait_r >= (slow_i ? 4'h6 : 4'h1);
   wire ctl_wr = take && we_i && addr_i == ihc_pkg::DEV_CTL0;
   wire kick = take && we_i && addr_i == ihc_pkg::DEV_SHIFT || ctl_wr && (wdata_i[5] || wdata_i[0]);
   assign val = addr_i == ihc_pkg::DEV_CTL0 ? ctl_r : addr_i == ihc_pkg::DEV_STATUS ?
      {~busy_i, 3'h0, 1'b1, ~nack_i, 2'h0} : addr_i == ihc_pkg::DEV_FLAG ? {busy_i, flag_r[6:0]} :
      addr_i == ihc_pkg::DEV_SHIFT ? 8'h5A : 8'h00;
   // Outside the answer cycle the data is inverted so a stale sample cannot pass.
   assign rdata_o = ack_o ? val : ~val;
   assign int_o = icnt_r != 4'h0 && icnt_r < 4'h5;
   always_ff @(posedge clk_i)
      if (rst_i)
         {ack_o, ctl_r, flag_r, wait_r, icnt_r, tcnt_r} <= '0;
      else
      begin
         ack_o <= take;
         wait_r <= (cs_i && !ack_o && !take) ? wait_r + 4'h1 : 4'h0;
         icnt_r <= kick ? 4'hA : icnt_r - {3'h0, icnt_r != 4'h0};
         tcnt_r <= ctl_wr ? 4'h3 : tcnt_r - {3'h0, tcnt_r != 4'h0};
         if (ctl_wr)
            ctl_r <= wdata_i;
         else if (tcnt_r == 4'h1)
            ctl_r[1:0] <= 2'h0;
         if (take && we_i && addr_i == ihc_pkg::DEV_FLAG)
            flag_r <= wdata_i;
      end
endmodule

// *** tb/ihc_host_chk.sv ***
// Assertion checker for the I2C host sequencer ports.
`timescale 1ns/1ns
module ihc_host_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic dev_cs_o,
   input wire logic dev_we_o,
   input wire logic [2:0] dev_addr_o,
   input wire logic [7:0] dev_wdata_o,
   input wire logic [7:0] dev_rdata_i,
   input wire logic dev_ack_i
);
   logic trig_r;
   wire ctl_acc = dev_cs_o && dev_ack_i && dev_addr_o == ihc_pkg::DEV_CTL0;
   wire ctl_w = dev_cs_o && dev_we_o && dev_addr_o == ihc_pkg::DEV_CTL0;
   // Set while a trigger bit may still be pending in the controller.
   always_ff @(posedge clk_i)
      if (rst_i)
         trig_r <= 1'b0;
      else if (ce_i && ctl_acc)
         trig_r <= dev_we_o ? dev_wdata_o[1:0] != 2'h0 : dev_rdata_i[1:0] != 2'h0;
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no bus answer");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   dev_hold_a: assert property (dev_cs_o && !dev_ack_i |=> dev_cs_o && $stable(dev_addr_o)
      && $stable(dev_wdata_o) && $stable(dev_we_o)) else $error("device request changed");
   dev_drop_a: assert property (dev_cs_o && dev_ack_i |=> !dev_cs_o) else $error("device request kept");
   trig_once_a: assert property (ctl_w && dev_wdata_o[1:0] != 2'h0 |-> !trig_r) else $error("trigger rewritten");
   start_wait_a: assert property (ctl_acc && dev_we_o && dev_wdata_o[1] |=> !dev_cs_o [*5])
      else $error("status read too soon");
   ctl_base_a: assert property (ctl_w && dev_wdata_o[7:5] == 3'h4 |-> dev_wdata_o[3:2] == 2'h3)
      else $error("enable without ack and wait bits");
   rst_clear_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !dev_cs_o) else $error("outputs after reset");
endmodule
bind ihc_host ihc_host_chk ihc_host_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .dev_cs_o(dev_cs_o), .dev_we_o(dev_we_o),
   .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_rdata_i(dev_rdata_i), .dev_ack_i(dev_ack_i));

// *** tb/ihc_host_tb.sv ***
// Self-checking testbench for the I2C host sequencer.
`timescale 1ns/1ns
module ihc_host_tb;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0, nack = 0, bsy = 0, scl = 1, sda = 1;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, q;
   logic [3:0] sel = 0;
   wire [31:0] dato;
   wire ack, irq, cs, dwe, dack, dint;
   wire [2:0] da;
   wire [7:0] dw, dr;
   int num_errors = 0, n_tests = 0, cyc_n = 0;
   initial forever #2 clk_i = ~clk_i;
   ihc_host #(.FREE_CYCLES(4), .FALL_CYC(1)) ihc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(dato), .wb_ack_o(ack), .irq_o(irq), .dev_cs_o(cs), .dev_we_o(dwe), .dev_addr_o(da),
      .dev_wdata_o(dw), .dev_rdata_i(dr), .dev_ack_i(dack), .transfer_interrupt_i(dint),
      .serial_clock_pin_i(scl), .serial_data_pin_i(sda));
   ihc_dev_model ihc_dev_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_i(cs), .we_i(dwe), .addr_i(da),
      .wdata_i(dw), .slow_i(slow), .nack_i(nack), .busy_i(bsy), .ack_o(dack), .rdata_o(dr), .int_o(dint));
   // ==========================================================
   // Bus cycles and checks
   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int t;
      t = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
      do
      begin
         @(posedge clk_i);
         t++;
      end
      while (ack !== 1'b1);
      chk("bus latency", 32'h2, t);
      q = dato;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 32'h0, 4'hF);
   endtask
   task automatic cmd(input logic [2:0] c);
      int t;
      t = 0;
      wr(ihc_pkg::HR_CMD, {29'h0, c});
      do
      begin
         rd(ihc_pkg::HR_STAT);
         t++;
      end
      while (q[0] !== 1'b0 && t < 500);
      chk("busy", 32'h0, {31'h0, q[0]});
   endtask
   task automatic irq_is(input logic [31:0] e);
      rd(ihc_pkg::HR_IRQ);
      chk("irq status", e, q);
      wr(ihc_pkg::HR_IRQ, 32'hF);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rd(ihc_pkg::HR_STAT);
      chk("stat", 32'h60, q);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20);
      chk("unmapped", 32'h0, q);
      wr(ihc_pkg::HR_CFG, 32'h0000_0302);
      wb(1'b1, ihc_pkg::HR_CFG, 32'h0001_FF00, 4'h2);
      rd(ihc_pkg::HR_CFG);
      chk("cfg", 32'h0000_FF02, q);
   endtask
   task automatic t_init;
      cmd(ihc_pkg::CMD_INIT);
      chk("irq idle", 32'h0, {31'h0, irq});
      wr(ihc_pkg::HR_MASK, 32'h1);
      repeat (2) @(posedge clk_i);
      #1 chk("irq level", 32'h1, {31'h0, irq});
      irq_is(32'h1);
      repeat (2) @(posedge clk_i);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic t_start;
      wr(ihc_pkg::HR_DATA, 32'hA0);
      cmd(ihc_pkg::CMD_START);
      rd(ihc_pkg::HR_STAT);
      chk("stat start", 32'h76, q);
      irq_is(32'h1);
   endtask
   task automatic t_nack;
      slow <= 1'b1;
      nack <= 1'b1;
      wr(ihc_pkg::HR_DATA, 32'h33);
      cmd(ihc_pkg::CMD_WRITE);
      rd(ihc_pkg::HR_STAT);
      chk("stat nack", 32'h74, q);
      irq_is(32'h3);
      nack <= 1'b0;
   endtask
   task automatic t_read;
      slow <= 1'b0;
      cmd(ihc_pkg::CMD_READ_LAST);
      rd(ihc_pkg::HR_DATA);
      chk("rx data", 32'h5A, q);
      irq_is(32'h1);
   endtask
   task automatic t_reject;
      bsy <= 1'b1;
      scl <= 1'b0;
      wr(ihc_pkg::HR_CFG, 32'h0002_FF02);
      wr(ihc_pkg::HR_CMD, {29'h0, ihc_pkg::CMD_START});
      repeat (20) @(posedge clk_i);
      rd(ihc_pkg::HR_STAT);
      chk("stat held", 32'h55, q);
      scl <= 1'b1;
      // The repeated command write lands while busy and must be ignored.
      cmd(ihc_pkg::CMD_START);
      rd(ihc_pkg::HR_STAT);
      chk("stat reject", 32'h7A, q);
      irq_is(32'h5);
      bsy <= 1'b0;
   endtask
   task automatic t_join(input int d, input logic [31:0] e);
      sda <= 1'b1;
      fork
         cmd(ihc_pkg::CMD_JOIN);
         begin
            repeat (d) @(posedge clk_i);
            sda <= 1'b0;
         end
      join
      irq_is(e);
   endtask
   always @(posedge clk_i)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 60000)
      begin
         num_errors++;
         final_report;
      end
   end
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_init;
      t_start;
      t_nack;
      t_read;
      t_reject;
      t_join(30, 32'h1);
      t_join(120, 32'h9);
      final_report;
   end
endmodule
